// ---- design/acp_pkg.sv ----
package acp_pkg;
    localparam int ACP_NSRC = 16;
    // alarm source bit positions
    localparam int SRC_PICKUP1 = 0;
    localparam int SRC_PICKUP2 = 1;
    localparam int SRC_MANIFOLD_AIR = 2;
    localparam int SRC_REMOTE_SPEED = 3;
    localparam int SRC_RACK_INPUT = 4;
    localparam int SRC_SPEED_SWITCH = 5;
    localparam int SRC_TORQUE_LIM = 6;
    localparam int SRC_MANIFOLD_LIM = 7;
    localparam int SRC_HIGH_ACT = 8;
    localparam int SRC_LINK_A_ERR = 9;
    localparam int SRC_LINK_B_ERR = 10;
    localparam int SRC_LINK_AB_ERR = 11;
    localparam int SRC_REG_LOW = 12;
    localparam int SRC_HIGH_SPEED_SW = 13;
    localparam int SRC_LOAD_SWITCH = 14;
    localparam int SRC_CLUTCH_FAIL = 15;
    localparam int ACP_SPD_W = 16;
    localparam int ACP_AIN_W = 12;
    localparam int ACP_CLK_HZ = 50_000_000;
    localparam int ACP_MS = 1;
    localparam int ACP_MS_CYC = ACP_CLK_HZ / 1000 * ACP_MS;
    localparam int ACP_MS_W = 16;
    localparam int ACP_SEC_MS = 1000;
    localparam int ACP_TMR_W = 20;
    localparam int ACP_CIN_MIN_S = 1;
    localparam int ACP_CIN_MAX_S = 120;
    localparam int ACP_CIN_W = 7;
    // fixed analog fault limits, codes for 2 mA and 21 mA on a 0..24 mA scale
    localparam logic [ACP_AIN_W-1:0] ACP_AIN_LO = 12'h155;
    localparam logic [ACP_AIN_W-1:0] ACP_AIN_HI = 12'hE00;
    typedef enum logic [2:0] {
        ACP_IDLE = 3'b000,
        ACP_RAMP = 3'b001,
        ACP_SYNC = 3'b011,
        ACP_CLOSED = 3'b010,
        ACP_ENGAGED = 3'b110,
        ACP_HOLD = 3'b111
    } acp_state_e;
endpackage : acp_pkg

// ---- design/acp_alarm_clutch.sv ----
`timescale 1ns/1ps
`default_nettype none
module acp_alarm_clutch (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // alarm configuration
    input wire logic i_minor_nc,
    input wire logic i_major_nc,
    input wire logic [acp_pkg::ACP_NSRC-1:0] i_minor_mask,
    input wire logic [acp_pkg::ACP_NSRC-1:0] i_major_mask,
    // fault sources from other logic, analog faults excluded
    input wire logic [acp_pkg::ACP_NSRC-1:0] i_fault_src,
    // analog input codes: manifold air, remote speed, rack
    input wire logic [acp_pkg::ACP_AIN_W-1:0] i_ain_manifold,
    input wire logic [acp_pkg::ACP_AIN_W-1:0] i_ain_remote,
    input wire logic [acp_pkg::ACP_AIN_W-1:0] i_ain_rack,
    // speed measurements and settings
    input wire logic [acp_pkg::ACP_SPD_W-1:0] i_speed_pickup1,
    input wire logic [acp_pkg::ACP_SPD_W-1:0] i_speed_pickup2,
    input wire logic [acp_pkg::ACP_SPD_W-1:0] i_engine_speed,
    input wire logic [acp_pkg::ACP_SPD_W-1:0] i_failsafe_speed,
    input wire logic [acp_pkg::ACP_SPD_W-1:0] i_idle_speed,
    input wire logic [acp_pkg::ACP_SPD_W-1:0] i_clutch_win_lo,
    input wire logic [acp_pkg::ACP_SPD_W-1:0] i_clutch_win_hi,
    input wire logic [acp_pkg::ACP_SPD_W-1:0] i_sync_tol,
    // clutch configuration
    input wire logic i_manual_clutch,
    input wire logic i_ctf_is_overspd_test,
    input wire logic [15:0] i_sync_time_ms,
    input wire logic [acp_pkg::ACP_CIN_W-1:0] i_clutch_in_s,
    // contact inputs (pins)
    input wire logic i_clutch_request,
    input wire logic i_clutch_engaged,
    input wire logic i_contact_f,
    // companion link data
    input wire logic i_companion_clutched,
    input wire logic [acp_pkg::ACP_SPD_W-1:0] i_master_speed,
    input wire logic i_companion_port,
    input wire logic i_link_a_fault,
    input wire logic i_link_b_fault,
    // side config and health
    input wire logic i_port_engine,
    input wire logic i_supply_ok,
    input wire logic i_cpu_ok,
    input wire logic i_watchdog_err,
    // contact outputs
    output logic o_minor_contact,
    output logic o_major_contact,
    output logic o_clutch_permissive,
    // speed reference control
    output logic o_ramp_to_idle,
    output logic o_follow_master,
    output logic o_declutch_cmd,
    output logic o_unload_ramp_dis,
    output logic o_load_share_ok,
    output logic o_port_side,
    // indicators
    output logic o_health_led,
    output logic [1:0] o_sensor_fail_indicator,
    output logic o_alarm1_led,
    output logic o_alarm2_led
);
    import acp_pkg::*;

    function automatic logic ain_bad(input logic [ACP_AIN_W-1:0] v);
        ain_bad = (v < ACP_AIN_LO) || (v > ACP_AIN_HI);
    endfunction : ain_bad

    function automatic logic in_band(input logic [ACP_SPD_W-1:0] v,
                                     input logic [ACP_SPD_W-1:0] lo,
                                     input logic [ACP_SPD_W-1:0] hi);
        in_band = (v >= lo) && (v <= hi);
    endfunction : in_band

    // two-flop synchronisers for contact pins
    logic [2:0] pin_s1_r, pin_s2_r;
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
        end else begin
            pin_s1_r <= {i_contact_f, i_clutch_engaged, i_clutch_request};
            pin_s2_r <= pin_s1_r;
        end
    end
    logic req, engaged, edc;
    assign req = pin_s2_r[0];
    assign engaged = pin_s2_r[1];
    assign edc = pin_s2_r[2] && !i_ctf_is_overspd_test;

    // alarm sources and outputs
    logic [ACP_NSRC-1:0] src;
    logic minor_act, major_act;
    logic [1:0] sens_fail;
    logic clutch_fail_r, clutch_fail_nxt;
    always_comb begin
        sens_fail[0] = i_speed_pickup1 < i_failsafe_speed;
        sens_fail[1] = i_speed_pickup2 < i_failsafe_speed;
        src = i_fault_src;
        src[SRC_PICKUP1] = i_fault_src[SRC_PICKUP1] | sens_fail[0];
        src[SRC_PICKUP2] = i_fault_src[SRC_PICKUP2] | sens_fail[1];
        src[SRC_MANIFOLD_AIR] = i_fault_src[SRC_MANIFOLD_AIR] | ain_bad(i_ain_manifold);
        src[SRC_REMOTE_SPEED] = i_fault_src[SRC_REMOTE_SPEED] | ain_bad(i_ain_remote);
        src[SRC_RACK_INPUT] = i_fault_src[SRC_RACK_INPUT] | ain_bad(i_ain_rack);
        src[SRC_LINK_A_ERR] = i_fault_src[SRC_LINK_A_ERR] | i_link_a_fault;
        src[SRC_LINK_B_ERR] = i_fault_src[SRC_LINK_B_ERR] | i_link_b_fault;
        // one healthy link is enough to keep exchanging values
        src[SRC_LINK_AB_ERR] = i_fault_src[SRC_LINK_AB_ERR] |
                               (i_link_a_fault & i_link_b_fault);
        src[SRC_CLUTCH_FAIL] = i_fault_src[SRC_CLUTCH_FAIL] | clutch_fail_r;
        minor_act = |(src & i_minor_mask);
        major_act = |(src & i_major_mask);
    end

    // clutch sequencer
    acp_state_e st_r, st_nxt;
    logic [ACP_MS_W-1:0] ms_cnt_r, ms_cnt_nxt;
    logic [ACP_TMR_W-1:0] tmr_r, tmr_nxt;
    logic manual_r;
    logic slave_r, slave_nxt;
    logic speed_ok, at_idle, ms_tick;
    logic [ACP_SPD_W-1:0] m_lo, m_hi;
    logic [ACP_TMR_W-1:0] cin_ms;
    always_comb begin
        ms_tick = ms_cnt_r == ACP_MS_W'(ACP_MS_CYC - 1);
        ms_cnt_nxt = ms_tick ? '0 : ms_cnt_r + 1'b1;
        at_idle = i_engine_speed <= i_idle_speed;
        m_lo = (i_master_speed > i_sync_tol) ? i_master_speed - i_sync_tol : '0;
        m_hi = i_master_speed + i_sync_tol;
        // clamp 1..120 s
        if (i_clutch_in_s < ACP_CIN_W'(ACP_CIN_MIN_S)) begin
            cin_ms = ACP_TMR_W'(ACP_CIN_MIN_S * ACP_SEC_MS);
        end else if (i_clutch_in_s > ACP_CIN_W'(ACP_CIN_MAX_S)) begin
            cin_ms = ACP_TMR_W'(ACP_CIN_MAX_S * ACP_SEC_MS);
        end else begin
            // widen before multiplying so the millisecond count cannot wrap
            cin_ms = ACP_TMR_W'(i_clutch_in_s) * ACP_TMR_W'(ACP_SEC_MS);
        end
        if (i_manual_clutch) begin
            speed_ok = in_band(i_engine_speed, i_clutch_win_lo, i_clutch_win_hi);
        end else if (slave_r) begin
            speed_ok = in_band(i_engine_speed, m_lo, m_hi);
        end else begin
            speed_ok = at_idle;
        end
        st_nxt = st_r;
        tmr_nxt = tmr_r;
        slave_nxt = slave_r;
        clutch_fail_nxt = clutch_fail_r;
        // one ms timer serves sync dwell and clutch-in wait; it saturates
        if (ms_tick && tmr_r != '1) begin
            tmr_nxt = tmr_r + 1'b1;
        end
        unique case (st_r)
            ACP_IDLE: begin
                tmr_nxt = '0;
                if (i_manual_clutch) begin
                    st_nxt = ACP_SYNC;
                end else if (req && !edc) begin
                    slave_nxt = i_companion_clutched;
                    clutch_fail_nxt = 1'b0;
                    st_nxt = (i_companion_clutched || at_idle) ? ACP_SYNC : ACP_RAMP;
                end
            end
            ACP_RAMP: begin
                tmr_nxt = '0;
                if (at_idle) begin
                    st_nxt = ACP_SYNC;
                end
            end
            ACP_SYNC: begin
                if (!speed_ok) begin
                    tmr_nxt = '0;
                end else if (tmr_r >= ACP_TMR_W'(i_sync_time_ms)) begin
                    tmr_nxt = '0;
                    st_nxt = ACP_CLOSED;
                end
            end
            ACP_CLOSED: begin
                if (engaged) begin
                    st_nxt = ACP_ENGAGED;
                end else if (tmr_r >= cin_ms) begin
                    clutch_fail_nxt = 1'b1;
                    st_nxt = ACP_HOLD;
                end
            end
            ACP_ENGAGED: begin
                if (!engaged && i_manual_clutch) begin
                    st_nxt = ACP_SYNC;
                end
            end
            ACP_HOLD: begin
                if (!req || i_manual_clutch) begin
                    st_nxt = ACP_IDLE;
                end
            end
            default: st_nxt = ACP_IDLE;
        endcase
        // auto request removal or emergency declutch opens at once
        if (!i_manual_clutch && st_r != ACP_IDLE && st_r != ACP_HOLD && (!req || edc)) begin
            st_nxt = edc ? ACP_HOLD : ACP_IDLE;
        end
        if (i_manual_clutch != manual_r) begin
            st_nxt = ACP_IDLE;
        end
    end

    // registered outputs
    logic minor_nxt, major_nxt, perm_nxt;
    logic ramp_nxt, follow_nxt, dcl_nxt, share_nxt, side_nxt;
    logic health_nxt, led1_nxt, led2_nxt;
    logic [1:0] sfail_nxt;
    always_comb begin
        minor_nxt = i_minor_nc ? !minor_act : minor_act;
        major_nxt = i_major_nc ? !major_act : major_act;
        perm_nxt = (st_nxt == ACP_CLOSED || st_nxt == ACP_ENGAGED) &&
                   (i_manual_clutch || !edc);
        ramp_nxt = st_nxt == ACP_RAMP;
        follow_nxt = slave_nxt && !i_manual_clutch &&
                     st_nxt != ACP_IDLE && st_nxt != ACP_HOLD;
        dcl_nxt = edc;
        share_nxt = engaged && (i_manual_clutch || req);
        side_nxt = i_port_engine;
        health_nxt = i_supply_ok && i_cpu_ok && !i_watchdog_err;
        sfail_nxt = sens_fail;
        led1_nxt = i_port_engine == i_companion_port;
        led2_nxt = i_link_a_fault && i_link_b_fault;
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= ACP_IDLE;
            ms_cnt_r <= '0;
            tmr_r <= '0;
            slave_r <= 1'b0;
            clutch_fail_r <= 1'b0;
            manual_r <= 1'b0;
            o_minor_contact <= 1'b0;
            o_major_contact <= 1'b0;
            o_clutch_permissive <= 1'b0;
            o_ramp_to_idle <= 1'b0;
            o_follow_master <= 1'b0;
            o_declutch_cmd <= 1'b0;
            o_unload_ramp_dis <= 1'b0;
            o_load_share_ok <= 1'b0;
            o_port_side <= 1'b0;
            o_health_led <= 1'b0;
            o_sensor_fail_indicator <= 2'h0;
            o_alarm1_led <= 1'b0;
            o_alarm2_led <= 1'b0;
        end else begin
            st_r <= st_nxt;
            ms_cnt_r <= ms_cnt_nxt;
            tmr_r <= tmr_nxt;
            slave_r <= slave_nxt;
            clutch_fail_r <= clutch_fail_nxt;
            manual_r <= i_manual_clutch;
            o_minor_contact <= minor_nxt;
            o_major_contact <= major_nxt;
            o_clutch_permissive <= perm_nxt;
            o_ramp_to_idle <= ramp_nxt;
            o_follow_master <= follow_nxt;
            o_declutch_cmd <= dcl_nxt;
            o_unload_ramp_dis <= dcl_nxt;
            o_load_share_ok <= share_nxt;
            o_port_side <= side_nxt;
            o_health_led <= health_nxt;
            o_sensor_fail_indicator <= sfail_nxt;
            o_alarm1_led <= led1_nxt;
            o_alarm2_led <= led2_nxt;
        end
    end
endmodule : acp_alarm_clutch
`default_nettype wire

// ---- testbench/acp_alarm_clutch_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module acp_alarm_clutch_checker (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // watched inputs
    input wire logic i_minor_nc,
    input wire logic i_major_nc,
    input wire logic [15:0] i_minor_mask,
    input wire logic [15:0] i_major_mask,
    input wire logic [15:0] i_fault_src,
    input wire logic [15:0] i_speed_pickup1,
    input wire logic [15:0] i_speed_pickup2,
    input wire logic [15:0] i_failsafe_speed,
    input wire logic i_manual_clutch,
    input wire logic i_ctf_is_overspd_test,
    input wire logic i_clutch_request,
    input wire logic i_clutch_engaged,
    input wire logic i_contact_f,
    input wire logic i_companion_port,
    input wire logic i_link_a_fault,
    input wire logic i_link_b_fault,
    input wire logic i_port_engine,
    input wire logic i_supply_ok,
    input wire logic i_cpu_ok,
    input wire logic i_watchdog_err,
    // watched outputs
    input wire logic o_minor_contact,
    input wire logic o_major_contact,
    input wire logic o_clutch_permissive,
    input wire logic o_declutch_cmd,
    input wire logic o_load_share_ok,
    input wire logic o_port_side,
    input wire logic o_health_led,
    input wire logic [1:0] o_sensor_fail_indicator,
    input wire logic o_alarm1_led,
    input wire logic o_alarm2_led
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    minor_cond_a:
    assert property ($past(i_resetn) && $past(|(i_minor_mask & i_fault_src))
        |-> o_minor_contact == !$past(i_minor_nc)) else $error("minor contact wrong");
    major_cond_a:
    assert property ($past(i_resetn) && $past(|(i_major_mask & i_fault_src))
        |-> o_major_contact == !$past(i_major_nc)) else $error("major contact wrong");
    health_led_a:
    assert property ($past(i_resetn) |-> o_health_led ==
        $past(i_supply_ok && i_cpu_ok && !i_watchdog_err)) else $error("health led wrong");
    sensor_fail_a:
    assert property ($past(i_resetn) |-> o_sensor_fail_indicator ==
        {$past(i_speed_pickup2 < i_failsafe_speed), $past(i_speed_pickup1 < i_failsafe_speed)})
        else $error("sensor indicator wrong");
    side_clash_a:
    assert property ($past(i_resetn) |-> o_alarm1_led == $past(i_port_engine == i_companion_port)
        && o_port_side == $past(i_port_engine)) else $error("side indication wrong");
    link_both_a:
    assert property ($past(i_resetn) |-> o_alarm2_led == $past(i_link_a_fault && i_link_b_fault))
        else $error("link led wrong");
    declutch_hold_a:
    assert property ((!i_manual_clutch && !i_ctf_is_overspd_test && i_contact_f) [*4]
        |=> !o_clutch_permissive && o_declutch_cmd) else $error("declutch not honoured");
    request_drop_a:
    assert property ((!i_manual_clutch && !i_clutch_request) [*5] |=> !o_clutch_permissive)
        else $error("permissive without request");
    engaged_need_a:
    assert property ((!i_clutch_engaged) [*4] |=> !o_load_share_ok)
        else $error("load share without clutch");
    cover property (o_clutch_permissive && o_load_share_ok);
    cover property (o_declutch_cmd);
    cover property (o_alarm2_led && o_alarm1_led);
endmodule : acp_alarm_clutch_checker
`default_nettype wire

// ---- testbench/acp_clutch_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module acp_clutch_model #(
    parameter int DLY = 6
) (
    // clock
    input wire logic i_ref_clk,
    // permissive contact from the block
    input wire logic i_permit,
    // clutch engaged contact back to the block
    output logic o_engaged
);
    logic [7:0] cnt_r = 8'h00;
    always_ff @(posedge i_ref_clk) begin
        if (!i_permit) begin
            cnt_r <= 8'h00;
        end else if (cnt_r != 8'hFF) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    // clutch closes some cycles after the permissive and opens with it
    assign o_engaged = i_permit && (cnt_r >= DLY[7:0]);
endmodule : acp_clutch_model
`default_nettype wire

// ---- testbench/acp_alarm_clutch_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module acp_alarm_clutch_tb_top;
    import acp_pkg::*;
    logic i_ref_clk = 1'b0, i_resetn = 1'b0, i_minor_nc = 1'b0, i_major_nc = 1'b0;
    logic i_manual_clutch = 1'b0, i_ctf_is_overspd_test = 1'b0, i_clutch_request = 1'b0;
    logic i_contact_f = 1'b0, i_companion_clutched = 1'b0, i_companion_port = 1'b0;
    logic i_link_a_fault = 1'b0, i_link_b_fault = 1'b0, i_port_engine = 1'b1;
    logic i_supply_ok = 1'b1, i_cpu_ok = 1'b1, i_watchdog_err = 1'b0, i_clutch_engaged;
    logic [15:0] i_minor_mask = 16'h0000, i_major_mask = 16'h0000, i_fault_src = 16'h0000;
    logic [11:0] i_ain_manifold = 12'h800, i_ain_remote = 12'h800, i_ain_rack = 12'h800;
    logic [15:0] i_speed_pickup1 = 16'h0400, i_speed_pickup2 = 16'h0400;
    logic [15:0] i_engine_speed = 16'h0100, i_failsafe_speed = 16'h0050;
    logic [15:0] i_idle_speed = 16'h0100, i_clutch_win_lo = 16'h0300, i_clutch_win_hi = 16'h0500;
    logic [15:0] i_sync_tol = 16'h0010, i_master_speed = 16'h0400, i_sync_time_ms = 16'h0000;
    logic [6:0] i_clutch_in_s = 7'h78;
    logic o_minor_contact, o_major_contact, o_clutch_permissive, o_ramp_to_idle, o_follow_master;
    logic o_declutch_cmd, o_unload_ramp_dis, o_load_share_ok, o_port_side, o_health_led;
    logic o_alarm1_led, o_alarm2_led;
    logic [1:0] o_sensor_fail_indicator;
    logic [11:0] ain_tab [4] = '{12'h154, 12'h155, 12'hE00, 12'hE01};
    int errors = 0;
    int n_tests = 0;
    acp_alarm_clutch u_acp_alarm_clutch (.*);
    acp_clutch_model #(.DLY(6)) u_acp_clutch_model (.i_ref_clk(i_ref_clk),
        .i_permit(o_clutch_permissive), .o_engaged(i_clutch_engaged));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic results();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : tick
    task automatic wait_perm(input logic v);
        int k;
        k = 0;
        while (o_clutch_permissive !== v) begin
            tick(1);
            k++;
            if (k > 300) begin
                errors++;
                results();
            end
        end
    endtask : wait_perm
    initial begin
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        for (int s = 0; s < 16; s++) begin
            @(posedge i_ref_clk);
            i_fault_src <= 16'h0001 << s;
            i_minor_mask <= 16'h0001 << s;
            i_major_mask <= ~(16'h0001 << s);
            i_minor_nc <= s[0];
            i_major_nc <= ~s[0];
            tick(3);
            chk(16'(o_minor_contact), 16'(!s[0]));
            chk(16'(o_major_contact), 16'(!s[0]));
        end
        for (int s = 0; s < 8; s++) begin
            @(posedge i_ref_clk);
            i_supply_ok <= s[0];
            i_cpu_ok <= s[1];
            i_watchdog_err <= s[2];
            tick(3);
            chk(16'(o_health_led), 16'(s == 3));
        end
        @(posedge i_ref_clk);
        i_fault_src <= 16'h0000;
        i_minor_mask <= 16'h0003;
        i_minor_nc <= 1'b0;
        i_speed_pickup1 <= 16'h004F;
        tick(3);
        chk(16'({o_sensor_fail_indicator, o_minor_contact}), 16'h0003);
        @(posedge i_ref_clk);
        i_speed_pickup1 <= 16'h0050;
        i_speed_pickup2 <= 16'h0000;
        tick(3);
        chk(16'(o_sensor_fail_indicator), 16'h0002);
        @(posedge i_ref_clk);
        i_speed_pickup2 <= 16'h0400;
        i_minor_mask <= 16'h0004;
        for (int s = 0; s < 4; s++) begin
            @(posedge i_ref_clk);
            i_ain_manifold <= ain_tab[s];
            tick(3);
            chk(16'(o_minor_contact), 16'(s == 0 || s == 3));
        end
        for (int s = 0; s < 4; s++) begin
            @(posedge i_ref_clk);
            i_port_engine <= s[0];
            i_companion_port <= s[1];
            i_link_a_fault <= s[0];
            i_link_b_fault <= s[1];
            i_minor_mask <= 16'h0800;
            tick(3);
            chk(16'({o_alarm1_led, o_alarm2_led, o_port_side, o_minor_contact}),
                16'({s[0] == s[1], s == 3, s[0], s == 3}));
        end
        @(posedge i_ref_clk);
        i_link_a_fault <= 1'b0;
        i_link_b_fault <= 1'b0;
        i_engine_speed <= 16'h0300;
        i_clutch_request <= 1'b1;
        tick(8);
        chk(16'({o_ramp_to_idle, o_clutch_permissive}), 16'h0002);
        @(posedge i_ref_clk);
        i_engine_speed <= 16'h0100;
        wait_perm(1'b1);
        tick(14);
        chk(16'({o_clutch_permissive, o_load_share_ok}), 16'h0003);
        @(posedge i_ref_clk);
        i_clutch_request <= 1'b0;
        tick(6);
        chk(16'(o_clutch_permissive), 16'h0000);
        @(posedge i_ref_clk);
        i_contact_f <= 1'b1;
        i_clutch_request <= 1'b1;
        tick(10);
        chk(16'({o_clutch_permissive, o_declutch_cmd, o_unload_ramp_dis}), 16'h0003);
        @(posedge i_ref_clk);
        i_ctf_is_overspd_test <= 1'b1;
        wait_perm(1'b1);
        @(posedge i_ref_clk);
        i_clutch_request <= 1'b0;
        i_contact_f <= 1'b0;
        i_ctf_is_overspd_test <= 1'b0;
        i_companion_clutched <= 1'b1;
        i_engine_speed <= 16'h0420;
        tick(6);
        @(posedge i_ref_clk);
        i_clutch_request <= 1'b1;
        tick(20);
        chk(16'({o_follow_master, o_clutch_permissive}), 16'h0002);
        @(posedge i_ref_clk);
        i_engine_speed <= 16'h0408;
        wait_perm(1'b1);
        @(posedge i_ref_clk);
        i_clutch_request <= 1'b0;
        i_manual_clutch <= 1'b1;
        i_companion_clutched <= 1'b0;
        i_engine_speed <= 16'h0200;
        tick(20);
        chk(16'(o_clutch_permissive), 16'h0000);
        @(posedge i_ref_clk);
        i_engine_speed <= 16'h0400;
        wait_perm(1'b1);
        @(posedge i_ref_clk);
        i_resetn <= 1'b0;
        tick(2);
        chk(16'({o_health_led, o_clutch_permissive, o_port_side}), 16'h0000);
        results();
    end
endmodule : acp_alarm_clutch_tb_top
bind acp_alarm_clutch acp_alarm_clutch_checker u_acp_alarm_clutch_checker (.*);
`default_nettype wire
